// ==== bench/serial_far_end.sv ====
// far-end model: serial frames on receive, shifter on transmit
`timescale 1ns/1ps
module serial_far_end (
   // clock and bench commands
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic [7:0] ch,
   input  wire logic       stop_val,
   input  wire logic       noisy,
   input  wire logic       idle_only,
   input  wire logic [4:0] idle_bits,
   output logic            busy,
   // transmit side
   input  wire logic       tx_data_wr,
   input  wire logic       tx_preamble_req,
   input  wire logic       break_queue_bit,
   output logic            tx_shifter_load,
   output logic            tx_busy,
   // receive side
   output logic            rx_start_det,
   output logic            rx_sample_stb,
   output logic            rx_sample_val,
   output logic            rx_bit_end,
   output logic            rx_bit_val,
   output logic            rx_char_done,
   output logic [8:0]      rx_char
);
   logic       shift_ff = 1'b0;
   logic [3:0] pre_ff   = 4'h0;

   // preamble and break hold the line from the moment they are queued
   assign tx_busy = shift_ff | tx_preamble_req | (pre_ff != 4'h0) |
                    break_queue_bit;

   // preamble lasts twelve cycles
   always @(posedge aclk)
      pre_ff <= tx_preamble_req ? 4'hc : pre_ff - {3'h0, pre_ff != 4'h0};

   // one bit time; outside strobes the sample and bit lines show the inverse, not old data
   task automatic bit_time(input logic v, input int n, input logic bad,
                           input logic last);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         rx_start_det  <= 1'b0;
         rx_sample_stb <= 1'b1;
         rx_sample_val <= (bad && i == 1) ? ~v : v;
      end
      @(posedge aclk);
      rx_sample_stb <= 1'b0;
      rx_sample_val <= ~v;
      rx_bit_end    <= 1'b1;
      rx_bit_val    <= v;
      rx_char_done  <= last;
      rx_char       <= last ? {1'b0, ch} : ~rx_char;
      @(posedge aclk);
      rx_bit_end   <= 1'b0;
      rx_bit_val   <= ~v;
      rx_char_done <= 1'b0;
   endtask : bit_time

   // receive frames: start, eight data bits lsb first, stop, idle bits
   initial begin
      {busy, rx_start_det, rx_sample_stb, rx_sample_val} = '0;
      {rx_bit_end, rx_bit_val, rx_char_done, rx_char} = '0;
      forever begin
         @(posedge aclk);
         if (go) begin
            busy <= 1'b1;
            if (!idle_only) begin
               rx_start_det <= 1'b1;
               bit_time(1'b0, 7, noisy, 1'b0);
               for (int b = 0; b < 8; b++)
                  bit_time(ch[b], 3, 1'b0, 1'b0);
               bit_time(stop_val, 3, 1'b0, 1'b1);
            end
            for (int k = 0; k < idle_bits; k++)
               bit_time(1'b1, 3, 1'b0, 1'b0);
            busy <= 1'b0;
         end
      end
   end

   // buffer moves into the shifter four cycles after a data write
   initial begin
      tx_shifter_load = 1'b0;
      forever begin
         @(posedge aclk);
         if (tx_data_wr) begin
            repeat (4) @(posedge aclk);
            tx_shifter_load <= 1'b1;
            shift_ff        <= 1'b1;
            @(posedge aclk);
            tx_shifter_load <= 1'b0;
            repeat (11) @(posedge aclk);
            shift_ff <= 1'b0;
         end
      end
   end
endmodule : serial_far_end

// ==== bench/uart_status_flags_tb_top.sv ====
// self-checking bench of the serial status flag block
`timescale 1ns/1ps
`include "uart_flags_params.svh"
module uart_status_flags_tb_top;
   logic        aclk, aresetn, go, stop_val, noisy, idle_only, busy;
   logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, tx_shifter_load, tx_busy;
   logic        tx_data_wr, tx_preamble_req, break_queue_bit;
   logic        tx_enable_bit, tx_irq, rx_start_det, rx_sample_stb;
   logic        rx_sample_val, rx_bit_end, rx_bit_val, rx_char_done;
   logic [8:0]  tx_data, rx_char;
   logic [7:0]  ch, exp_st;
   logic [4:0]  idle_bits;
   int          bad_count, checks_done;

   uart_status_flags uart_status_flags_i (.*);
   serial_far_end serial_far_end_i (.*);

   // 40 MHz bus clock
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   // expected parity error: odd select wants an odd count of ones
   function automatic logic par_err(input logic [7:0] c, input logic odd);
      return (^c) != odd;
   endfunction : par_err

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask : chk

   task automatic complete_run;
      if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   // a wait that ran out of cycles counts as a mismatch and ends the run
   task automatic guard(input int n);
      if (n >= 400) begin
         chk(32'h0, 32'h1);
         complete_run;
      end
   endtask : guard

   // address and data offered together, bready held until bvalid
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin @(posedge aclk); n++; end
      while (s_axi_awready !== 1'b1 && n < 400);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      do begin @(posedge aclk); n++; end
      while (s_axi_bvalid !== 1'b1 && n < 400);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      guard(n);
      @(posedge aclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin @(posedge aclk); n++; end
      while (s_axi_arready !== 1'b1 && n < 400);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end
      while (s_axi_rvalid !== 1'b1 && n < 400);
      s_axi_rready <= 1'b0;
      rd   = s_axi_rdata;
      resp = s_axi_rresp;
      guard(n);
      @(posedge aclk);
   endtask : axi_rd

   // status read doubles as the arming read of a clear sequence
   task automatic st(input logic [7:0] m, input logic [7:0] e);
      axi_rd(`OFS_STATUS_ONE);
      chk({24'h0, rd[7:0] & m}, {24'h0, e});
   endtask : st

   task automatic send(input logic [7:0] c, input logic sv, input logic nz,
                       input logic io, input logic [4:0] ib);
      int n;
      n = 0;
      ch        <= c;
      stop_val  <= sv;
      noisy     <= nz;
      idle_only <= io;
      idle_bits <= ib;
      go        <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do begin @(posedge aclk); n++; end
      while (busy !== 1'b0 && n < 400);
      guard(n);
   endtask : send

   // ld high: wait for a shifter load, low: wait for the line to go quiet
   task automatic wait_tx(input logic ld);
      int n;
      n = 0;
      while ((ld ? tx_shifter_load : !tx_busy) !== 1'b1 && n < 400) begin
         @(posedge aclk);
         n++;
      end
      guard(n);
   endtask : wait_tx

   // main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, go} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = {2'h0, 4'hf};
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {ch, stop_val, noisy, idle_only, idle_bits} = '0;
      {bad_count, checks_done} = '0;
      seed = 32'h00012cba;
      aresetn = 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      st(8'hff, 8'hc0);
      axi_wr(`OFS_STATUS_ONE, 32'h0000003f);
      chk({30'h0, resp}, {30'h0, `RESP_OKAY});
      st(8'hff, 8'hc0);
      axi_rd(4'hc);
      chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
      // transmit: arm, write data, buffer reload, line idle again
      axi_wr(`OFS_CONTROL, 32'h00000080);
      chk({31'h0, tx_irq}, 32'h1);
      seed = xs(seed);
      axi_rd(`OFS_STATUS_ONE);
      axi_wr(`OFS_DATA_BUFFER, {24'h0, seed[7:0]});
      chk({23'h0, tx_data}, {24'h0, seed[7:0]});
      chk({31'h0, tx_irq}, 32'h0);
      st(8'hc0, 8'h00);
      wait_tx(1'b1);
      st(8'hc0, 8'h80);
      wait_tx(1'b0);
      st(8'hc0, 8'hc0);
      axi_wr(`OFS_CONTROL, 32'h00000082);
      chk({31'h0, tx_enable_bit}, 32'h1);
      st(8'h40, 8'h00);
      wait_tx(1'b0);
      st(8'h40, 8'h40);
      axi_wr(`OFS_CONTROL, 32'h00000083);
      st(8'h40, 8'h00);
      axi_wr(`OFS_CONTROL, 32'h00000002);
      // random characters, both parity senses, noise on one start bit
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         axi_wr(`OFS_CONTROL, {28'h0, i[0], 3'b100});
         send(seed[7:0], 1'b1, i == 2, 1'b0, 5'h00);
         exp_st = {5'h04, i == 2, 1'b0, par_err(seed[7:0], i[0])};
         st(8'h3f, exp_st);
         axi_rd(`OFS_DATA_BUFFER);
         chk(rd, {24'h0, seed[7:0]});
         st(8'h3f, 8'h00);
      end
      // unread character: the next one is lost with its framing error
      axi_wr(`OFS_CONTROL, 32'h00000000);
      send(8'h5a, 1'b1, 1'b0, 1'b0, 5'h00);
      send(8'ha5, 1'b0, 1'b0, 1'b0, 5'h00);
      st(8'h3f, 8'h28);
      axi_rd(`OFS_DATA_BUFFER);
      chk(rd, 32'h0000005a);
      st(8'h3f, 8'h00);
      send(8'h3c, 1'b0, 1'b0, 1'b0, 5'h00);
      st(8'h3f, 8'h22);
      axi_rd(`OFS_DATA_BUFFER);
      st(8'h3f, 8'h00);
      // arming read saw nothing, so the later data read clears nothing
      send(8'h11, 1'b1, 1'b0, 1'b0, 5'h00);
      axi_rd(`OFS_DATA_BUFFER);
      st(8'h20, 8'h20);
      axi_rd(`OFS_DATA_BUFFER);
      // idle counted from the start bit: eight ones, stop, one idle bit
      send(8'hff, 1'b1, 1'b0, 1'b0, 5'h01);
      st(8'h30, 8'h30);
      axi_rd(`OFS_DATA_BUFFER);
      st(8'h10, 8'h00);
      send(8'h00, 1'b1, 1'b0, 1'b1, 5'h0c);
      st(8'h10, 8'h00);
      // idle counted after the stop bit only
      axi_wr(`OFS_CONTROL, 32'h00000010);
      send(8'hff, 1'b1, 1'b0, 1'b0, 5'h09);
      st(8'h30, 8'h20);
      send(8'h00, 1'b1, 1'b0, 1'b1, 5'h01);
      st(8'h10, 8'h10);
      axi_rd(`OFS_DATA_BUFFER);
      // long break detect keeps full and framing flags down
      axi_wr(`OFS_CONTROL, 32'h00000040);
      send(8'h77, 1'b0, 1'b0, 1'b0, 5'h00);
      st(8'h3f, 8'h00);
      complete_run;
   end
endmodule : uart_status_flags_tb_top

// ==== rtl/uart_flags_params.svh ====
// offsets, field positions and counts of the serial status flag block
`ifndef UART_FLAGS_PARAMS_SVH
`define UART_FLAGS_PARAMS_SVH
`define OFS_STATUS_ONE   4'h0
`define OFS_DATA_BUFFER  4'h4
`define OFS_CONTROL      4'h8
`define BIT_TX_EMPTY     7
`define BIT_TX_COMPLETE  6
`define BIT_RX_FULL      5
`define BIT_IDLE         4
`define BIT_OVERRUN      3
`define BIT_NOISE        2
`define BIT_FRAME_ERR    1
`define BIT_PARITY_ERR   0
`define CTL_BREAK_QUEUE  0
`define CTL_TX_ENABLE    1
`define CTL_PARITY_ON    2
`define CTL_PARITY_ODD   3
`define CTL_IDLE_AFTER   4
`define CTL_NINE_BIT     5
`define CTL_LIN_LONG     6
`define CTL_TX_IRQ_EN    7
`define STATUS_RESET     8'hc0
`define CONTROL_RESET    8'h00
`define CHAR_BITS_EIGHT  4'ha
`define CHAR_BITS_NINE   4'hb
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ==== rtl/uart_flags_pkg.sv ====
// types shared by the serial status flag block
package uart_flags_pkg;
   typedef logic [1:0] resp_t;
   typedef logic [7:0] flags_t;
   typedef enum logic [1:0] {
      reg_status,
      reg_data,
      reg_control,
      reg_none
   } reg_sel_t;
endpackage : uart_flags_pkg

// ==== rtl/uart_status_flags.sv ====
// status register one of the serial port with its flag logic
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "uart_flags_params.svh"
module uart_status_flags (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // transmitter side
   input  wire logic        tx_shifter_load,
   input  wire logic        tx_busy,
   output logic [8:0]       tx_data,
   output logic             tx_data_wr,
   output logic             tx_preamble_req,
   output logic             break_queue_bit,
   output logic             tx_enable_bit,
   output logic             tx_irq,
   // receiver side
   input  wire logic        rx_start_det,
   input  wire logic        rx_sample_stb,
   input  wire logic        rx_sample_val,
   input  wire logic        rx_bit_end,
   input  wire logic        rx_bit_val,
   input  wire logic        rx_char_done,
   input  wire logic [8:0]  rx_char
);

   // control and flag state
   logic [7:0] ctl_ff;
   logic [7:0] flags_ff;
   logic [7:0] armed_ff;
   logic [8:0] rx_data_ff;
   logic [8:0] tx_data_ff;
   logic       tx_data_wr_ff;
   logic       tx_pre_ff;
   logic [3:0] idle_cnt_ff;
   logic       idle_armed_ff;
   logic       in_frame_ff;
   logic       have_first_ff;
   logic       first_val_ff;
   logic       noise_acc_ff;

   // bus state
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;

   // decoded events
   logic wr_take;
   logic rd_take;
   uart_flags_pkg::reg_sel_t wr_sel;
   uart_flags_pkg::reg_sel_t rd_sel;
   logic status_rd;
   logic data_rd;
   logic data_wr;
   logic ctl_wr;
   logic te_rise;
   logic sbk_one;
   logic [7:0] nxt_ctl;
   logic       accept;
   logic       sample_bad;
   logic       parity_bad;
   logic [3:0] char_bits;
   logic [7:0] clr_mask;
   logic [7:0] set_mask;
   logic [7:0] nxt_flags;
   logic       idle_hit;

   // one address decoder serves both read and write channels
   function automatic uart_flags_pkg::reg_sel_t dec(input logic [3:0] a);
      case (a)
         `OFS_STATUS_ONE:  dec = uart_flags_pkg::reg_status;
         `OFS_DATA_BUFFER: dec = uart_flags_pkg::reg_data;
         `OFS_CONTROL:     dec = uart_flags_pkg::reg_control;
         default:          dec = uart_flags_pkg::reg_none;
      endcase
   endfunction : dec

   // write taken only with address and data together, one at a time
   assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign rd_take       = s_axi_arvalid & ~rvalid_ff;
   assign s_axi_arready = rd_take;
   assign wr_sel        = dec(s_axi_awaddr);
   assign rd_sel        = dec(s_axi_araddr);

   // access strobes; byte lane zero must be enabled for data and control
   assign status_rd = rd_take & (rd_sel == uart_flags_pkg::reg_status);
   assign data_rd   = rd_take & (rd_sel == uart_flags_pkg::reg_data);
   assign data_wr   = wr_take & s_axi_wstrb[0]
                    & (wr_sel == uart_flags_pkg::reg_data);
   assign ctl_wr    = wr_take & s_axi_wstrb[0]
                    & (wr_sel == uart_flags_pkg::reg_control);
   assign nxt_ctl   = ctl_wr ? s_axi_wdata[7:0] : ctl_ff;
   assign te_rise   = ctl_wr & ~ctl_ff[`CTL_TX_ENABLE]
                    & nxt_ctl[`CTL_TX_ENABLE];
   assign sbk_one   = ctl_wr & nxt_ctl[`CTL_BREAK_QUEUE];

   // write response: status one answers okay but stores nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `RESP_OKAY;
      end else if (wr_take) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= (wr_sel == uart_flags_pkg::reg_none) ?
                      `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // read data; status shows flag state, unmapped reads zero with error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= `RESP_OKAY;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= `RESP_OKAY;
         case (rd_sel)
            uart_flags_pkg::reg_status:  rdata_ff <= {24'h0, flags_ff};
            uart_flags_pkg::reg_data:    rdata_ff <= {23'h0, rx_data_ff};
            uart_flags_pkg::reg_control: rdata_ff <= {24'h0, ctl_ff};
            default: begin
               rdata_ff <= 32'h0000_0000;
               rresp_ff <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;

   // control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_ff <= `CONTROL_RESET;
      end else begin
         ctl_ff <= nxt_ctl;
      end
   end

   // transmit buffer and one-cycle requests to the transmitter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_data_ff    <= 9'h000;
         tx_data_wr_ff <= 1'b0;
         tx_pre_ff     <= 1'b0;
      end else begin
         tx_data_wr_ff <= data_wr;
         tx_pre_ff     <= te_rise;
         if (data_wr) begin
            tx_data_ff <= s_axi_wdata[8:0];
         end
      end
   end

   assign tx_data         = tx_data_ff;
   assign tx_data_wr      = tx_data_wr_ff;
   assign tx_preamble_req = tx_pre_ff;
   assign break_queue_bit = ctl_ff[`CTL_BREAK_QUEUE];
   assign tx_enable_bit   = ctl_ff[`CTL_TX_ENABLE];
   // level request, follows the flag with no latch of its own
   assign tx_irq = flags_ff[`BIT_TX_EMPTY]
                 & ctl_ff[`CTL_TX_IRQ_EN];

   // noise: each sample is compared with the first of its bit
   assign sample_bad = rx_sample_stb & have_first_ff
                     & (rx_sample_val != first_val_ff);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_first_ff <= 1'b0;
         first_val_ff  <= 1'b0;
         noise_acc_ff  <= 1'b0;
      end else begin
         if (rx_bit_end | rx_start_det) begin
            have_first_ff <= 1'b0;
         end else if (rx_sample_stb & ~have_first_ff) begin
            have_first_ff <= 1'b1;
            first_val_ff  <= rx_sample_val;
         end
         if (rx_start_det) begin
            noise_acc_ff <= 1'b0;
         end else if (sample_bad) begin
            noise_acc_ff <= 1'b1;
         end
      end
   end

   // parity over all received bits; odd select expects an odd total
   assign char_bits  = ctl_ff[`CTL_NINE_BIT] ?
                       `CHAR_BITS_NINE : `CHAR_BITS_EIGHT;
   assign parity_bad = ctl_ff[`CTL_PARITY_ON]
                     & ((ctl_ff[`CTL_NINE_BIT] ? ^rx_char : ^rx_char[7:0])
                        != ctl_ff[`CTL_PARITY_ODD]);

   // a character lands only if the buffer is free and long break is off
   assign accept = rx_char_done & ~flags_ff[`BIT_RX_FULL]
                 & ~ctl_ff[`CTL_LIN_LONG];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data_ff <= 9'h000;
      end else if (accept) begin
         rx_data_ff <= rx_char;  // new data dropped on overrun
      end
   end

   // idle counter: high bit times since start bit, or since stop bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_cnt_ff <= 4'h0;
         in_frame_ff <= 1'b0;
      end else begin
         if (rx_start_det) begin
            in_frame_ff <= 1'b1;
         end else if (rx_char_done) begin
            in_frame_ff <= 1'b0;
         end
         if (rx_start_det) begin
            idle_cnt_ff <= 4'h0;
         end else if (rx_char_done & ctl_ff[`CTL_IDLE_AFTER]) begin
            idle_cnt_ff <= 4'h0;  // stop bit not counted
         end else if (rx_bit_end) begin
            if (!rx_bit_val) begin
               idle_cnt_ff <= 4'h0;
            end else if (in_frame_ff & ctl_ff[`CTL_IDLE_AFTER]) begin
               idle_cnt_ff <= 4'h0;  // trailing ones ignored
            end else if (idle_cnt_ff != char_bits) begin
               idle_cnt_ff <= idle_cnt_ff + 4'h1;
            end
         end
      end
   end

   // idle fires once when the count reaches a full character time
   assign idle_hit = idle_armed_ff & (idle_cnt_ff == char_bits);

   // rearmed only by a character reaching the data register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_armed_ff <= 1'b0;
      end else if (accept) begin
         idle_armed_ff <= 1'b1;
      end else if (idle_hit) begin
         idle_armed_ff <= 1'b0;
      end
   end

   // flags that set this cycle
   always_comb begin
      set_mask = 8'h00;
      set_mask[`BIT_TX_EMPTY]    = tx_shifter_load;
      // a queuing access is activity already, else set would beat clear
      set_mask[`BIT_TX_COMPLETE] = flags_ff[`BIT_TX_EMPTY]
                                 & ~tx_busy & ~tx_data_wr_ff
                                 & ~(data_wr | te_rise | sbk_one);
      set_mask[`BIT_RX_FULL]     = accept;
      set_mask[`BIT_IDLE]        = idle_hit;
      set_mask[`BIT_OVERRUN]     = rx_char_done & flags_ff[`BIT_RX_FULL]
                                 & ~ctl_ff[`CTL_LIN_LONG];
   end

   // armed flags that the completing access clears
   always_comb begin
      clr_mask = 8'h00;
      if (data_wr) begin
         clr_mask[`BIT_TX_EMPTY]    = armed_ff[`BIT_TX_EMPTY];
      end
      if (data_wr | te_rise | sbk_one) begin
         clr_mask[`BIT_TX_COMPLETE] = armed_ff[`BIT_TX_COMPLETE];
      end
      if (data_rd) begin
         clr_mask[5:0] = armed_ff[5:0];
      end
   end

   // set wins over clear; noise, framing and parity flags are reloaded whole on transfer
   always_comb begin
      nxt_flags = (flags_ff & ~clr_mask) | set_mask;
      if (accept) begin
         nxt_flags[`BIT_NOISE]      = noise_acc_ff | sample_bad;
         nxt_flags[`BIT_FRAME_ERR]  = ~rx_bit_val;
         nxt_flags[`BIT_PARITY_ERR] = parity_bad;
      end
   end

   // status one has no write path, only these set and clear terms
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_ff <= `STATUS_RESET;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // arming: remember flags that were one at the status read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed_ff <= 8'h00;
      end else if (status_rd) begin
         armed_ff <= flags_ff;
      end else begin
         armed_ff <= armed_ff & ~clr_mask;
      end
   end

   // checks
   sequence s_status_read;
      status_rd & flags_ff[`BIT_RX_FULL];
   endsequence
   sequence s_data_read;
      data_rd & ~accept;
   endsequence

   a_rx_full_clear: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_status_read ##[2:8] s_data_read
      |=> ~flags_ff[`BIT_RX_FULL])
      else $error("rx full not cleared by read sequence");

   a_rx_full_set: assert property (
      @(posedge aclk) disable iff (!aresetn)
      accept |=> flags_ff[`BIT_RX_FULL] && rx_data_ff == $past(rx_char))
      else $error("character transfer did not set rx full");

   a_overrun_keep: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rx_char_done & flags_ff[`BIT_RX_FULL] & ~ctl_ff[`CTL_LIN_LONG]
      |=> flags_ff[`BIT_OVERRUN] && $stable(rx_data_ff))
      else $error("overrun not flagged or data replaced");

   a_no_status_wr: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_take & (wr_sel == uart_flags_pkg::reg_status) & ~tx_shifter_load
      & ~idle_hit & ~accept & ~rx_char_done & ~data_rd & ~data_wr
      & ~te_rise & ~sbk_one
      & (tx_busy | ~flags_ff[`BIT_TX_EMPTY] | flags_ff[`BIT_TX_COMPLETE])
      |=> $stable(flags_ff))
      else $error("write changed status one");

   a_tx_empty_set: assert property (
      @(posedge aclk) disable iff (!aresetn)
      tx_shifter_load |=> flags_ff[`BIT_TX_EMPTY])
      else $error("tx empty not set on shifter load");

   a_tx_empty_clr: assert property (
      @(posedge aclk) disable iff (!aresetn)
      data_wr & armed_ff[`BIT_TX_EMPTY] & ~tx_shifter_load
      |=> ~flags_ff[`BIT_TX_EMPTY] && tx_data_wr)
      else $error("tx empty clear sequence failed");

   a_tx_irq_level: assert property (
      @(posedge aclk) disable iff (!aresetn)
      tx_irq == (flags_ff[`BIT_TX_EMPTY] & ctl_ff[`CTL_TX_IRQ_EN]))
      else $error("tx interrupt does not follow flag");

   a_lin_blocks: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rx_char_done & ctl_ff[`CTL_LIN_LONG] & ~flags_ff[`BIT_RX_FULL]
      |=> ~flags_ff[`BIT_RX_FULL])
      else $error("rx full set under long break detect");

   a_idle_once: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(flags_ff[`BIT_IDLE]) |-> ~idle_armed_ff)
      else $error("idle left armed after setting");

   a_frame_err: assert property (
      @(posedge aclk) disable iff (!aresetn)
      accept & ~rx_bit_val |=> flags_ff[`BIT_FRAME_ERR]
      && flags_ff[`BIT_RX_FULL])
      else $error("framing error not set with rx full");

endmodule : uart_status_flags
